//--- design/display_cache_sdram_ctrl.sv
// Display cache SDRAM control: special modes, refresh, diagnostic registers and legacy window claim.
// Operation
// RQ1 - Refresh field bits 4:3: 00 stops refresh, 01 normal (reset), others reserved.
// RQ2 - Software restores normal refresh soon after testing; long disabling loses data.
// RQ3 - Special mode field bits 2:0: 000 normal (reset); 101 and 11X reserved.
// RQ4 - Mode 001 turns every cache cycle into an SDRAM NOP command.
// RQ5 - Mode 010 turns every cache cycle into an all-bank precharge.
// RQ6 - Mode 011 turns every cycle into mode register set on twelve address lines.
// RQ7 - Mode register set: address 2:0 burst, 3 wrap, 6:4 latency.
// RQ8 - Mode register set forces address bits 11:7 to zero.
// RQ9 - Mode 100 turns every cache cycle into a CBR refresh.
// RQ10 - Software selects NOP mode before any other special mode.
// RQ11 - Software picks host addresses placing the mode value on address bits 6:0.
// RQ12 - Diagnostic registers answer in I/O and memory space at equal offsets.
// RQ13 - Index bits 3:0 select the graphics register behind the data port.
// RQ14 - Index bits 7:4 always read as zero.
// RQ15 - Misc output written at 3C2h, read at 3CCh, reset zero.
// RQ16 - Misc output bit 1 low refuses legacy window cycles; high claims them.
// RQ17 - Legacy enable bit never affects linear frame buffer accesses.
// RQ18 - Each host cache access in a special mode yields exactly one command.
`default_nettype none
module display_cache_sdram_ctrl (
    // Clock and reset.
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    // Register access, I/O or memory space.
    input  wire logic        reg_req_in,
    input  wire logic        reg_is_mem_in,
    input  wire logic        reg_write_in,
    input  wire logic [15:0] reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    output logic             reg_ack_out,
    output logic             reg_hit_out,
    output logic      [7:0]  reg_rdata_out,
    // Processor memory cycle claim.
    input  wire logic [31:0] cpu_addr_in,
    input  wire logic        lfb_hit_in,
    output logic             cpu_claim_out,
    // Display cache cycles from the host side.
    input  wire logic        dc_req_in,
    input  wire logic        dc_write_in,
    input  wire logic [11:0] dc_addr_in,
    output logic             dc_ready_out,
    output logic             dc_done_out,
    // SDRAM command pins.
    output logic             ras_n_out,
    output logic             cas_n_out,
    output logic             we_n_out,
    output logic      [11:0] local_mem_addr_out
);
    logic [7:0]               dram_ctrl_hi_r;
    logic [7:0]               misc_out_r;
    logic [7:0]               gfx_index_r;
    logic [7:0]               gfx_ctrl_regs_r [dc_ctrl_pkg::GFX_REG_COUNT];
    logic [1:0]               refresh_rate_field;
    logic [2:0]               special_mode_field;
    logic [11:0]              refresh_cnt_r;
    logic                     refresh_pend_r;
    dc_ctrl_pkg::ctrl_state_t state_r;
    logic [2:0]               enc_cmd;
    logic [11:0]              enc_addr;
    logic                     wr_en;
    logic                     take_host;
    logic                     take_refresh;

    // Match an address in either space; the DRAM control register lives in memory space only.
    function automatic logic addr_is(input logic [15:0] a, input logic [15:0] target);
        addr_is = (a == target);
    endfunction

    assign refresh_rate_field = dram_ctrl_hi_r[dc_ctrl_pkg::REFRESH_LSB +: 2];
    assign special_mode_field = dram_ctrl_hi_r[dc_ctrl_pkg::MODE_LSB +: 3];
    assign wr_en              = reg_req_in && reg_write_in;

    // RQ1 RQ3 dram control register
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            dram_ctrl_hi_r <= dc_ctrl_pkg::DRAM_CTRL_HI_RESET;
        end else if (wr_en && reg_is_mem_in && addr_is(reg_addr_in, dc_ctrl_pkg::DRAM_CTRL_HI_ADDR)) begin
            dram_ctrl_hi_r <= reg_wdata_in & dc_ctrl_pkg::DRAM_CTRL_HI_MASK;
        end
    end

    // RQ15 misc output write port
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            misc_out_r <= dc_ctrl_pkg::MISC_OUT_RESET;
        end else if (wr_en && addr_is(reg_addr_in, dc_ctrl_pkg::MISC_OUT_WR_ADDR)) begin
            misc_out_r <= reg_wdata_in & dc_ctrl_pkg::MISC_OUT_MASK;
        end
    end

    // RQ14 index upper bits zero
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            gfx_index_r <= dc_ctrl_pkg::GFX_REG_RESET;
        end else if (wr_en && addr_is(reg_addr_in, dc_ctrl_pkg::GFX_INDEX_ADDR)) begin
            gfx_index_r <= reg_wdata_in & dc_ctrl_pkg::GFX_INDEX_MASK;
        end
    end

    // RQ13 indexed data port write
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            for (int i = 0; i < dc_ctrl_pkg::GFX_REG_COUNT; i++) begin
                gfx_ctrl_regs_r[i] <= dc_ctrl_pkg::GFX_REG_RESET;
            end
        end else if (wr_en && addr_is(reg_addr_in, dc_ctrl_pkg::GFX_DATA_ADDR)
                     && (gfx_index_r < 8'(dc_ctrl_pkg::GFX_REG_COUNT))) begin
            gfx_ctrl_regs_r[gfx_index_r[3:0]] <= reg_wdata_in;
        end
    end

    // RQ12 read decode both spaces
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            reg_ack_out   <= 1'b0;
            reg_hit_out   <= 1'b0;
            reg_rdata_out <= 8'h00;
        end else begin
            reg_ack_out   <= reg_req_in;
            reg_hit_out   <= 1'b0;
            reg_rdata_out <= 8'h00;
            if (reg_req_in) begin
                if (reg_is_mem_in && addr_is(reg_addr_in, dc_ctrl_pkg::DRAM_CTRL_HI_ADDR)) begin
                    reg_hit_out   <= 1'b1;
                    reg_rdata_out <= reg_write_in ? 8'h00 : dram_ctrl_hi_r;
                end else if (addr_is(reg_addr_in, dc_ctrl_pkg::MISC_OUT_WR_ADDR)) begin
                    reg_hit_out <= reg_write_in;
                end else if (addr_is(reg_addr_in, dc_ctrl_pkg::MISC_OUT_RD_ADDR)) begin
                    // RQ15 misc output readback
                    reg_hit_out   <= !reg_write_in;
                    reg_rdata_out <= reg_write_in ? 8'h00 : misc_out_r;
                end else if (addr_is(reg_addr_in, dc_ctrl_pkg::GFX_INDEX_ADDR)) begin
                    reg_hit_out   <= 1'b1;
                    reg_rdata_out <= reg_write_in ? 8'h00 : gfx_index_r;
                end else if (addr_is(reg_addr_in, dc_ctrl_pkg::GFX_DATA_ADDR)) begin
                    reg_hit_out <= 1'b1;
                    if (!reg_write_in && gfx_index_r < 8'(dc_ctrl_pkg::GFX_REG_COUNT)) begin
                        reg_rdata_out <= gfx_ctrl_regs_r[gfx_index_r[3:0]];
                    end
                end
            end
        end
    end

    // RQ16 RQ17 legacy window claim
    assign cpu_claim_out = (cpu_addr_in >= dc_ctrl_pkg::LEGACY_LO && cpu_addr_in <= dc_ctrl_pkg::LEGACY_HI)
                           ? misc_out_r[dc_ctrl_pkg::LEGACY_EN_BIT] : lfb_hit_in;

    // RQ1 refresh timer gating
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            refresh_cnt_r  <= dc_ctrl_pkg::REFRESH_COUNT;
            refresh_pend_r <= 1'b0;
        end else if (refresh_rate_field != dc_ctrl_pkg::REFRESH_NORMAL) begin
            refresh_cnt_r  <= dc_ctrl_pkg::REFRESH_COUNT;
            refresh_pend_r <= 1'b0;
        end else begin
            if (refresh_cnt_r == 12'h000) begin
                refresh_cnt_r <= dc_ctrl_pkg::REFRESH_COUNT;
            end else begin
                refresh_cnt_r <= refresh_cnt_r - 12'h001;
            end
            // A new tick wins over the clear of the same cycle.
            if (refresh_cnt_r == 12'h000) begin
                refresh_pend_r <= 1'b1;
            end else if (take_refresh) begin
                refresh_pend_r <= 1'b0;
            end
        end
    end

    // Host cycles win over a pending refresh; refresh waits for the next idle cycle.
    assign dc_ready_out = (state_r == dc_ctrl_pkg::ST_IDLE);
    assign take_host    = dc_ready_out && dc_req_in;
    assign take_refresh = dc_ready_out && !dc_req_in && refresh_pend_r;

    sdram_cmd_encoder u_enc (
        .mode_in  (special_mode_field),
        .write_in (dc_write_in),
        .addr_in  (dc_addr_in),
        .cmd_out  (enc_cmd),
        .addr_out (enc_addr)
    );

    // RQ18 one command per cycle
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state_r            <= dc_ctrl_pkg::ST_IDLE;
            {ras_n_out, cas_n_out, we_n_out} <= dc_ctrl_pkg::CMD_NOP;
            local_mem_addr_out <= 12'h000;
            dc_done_out        <= 1'b0;
        end else begin
            {ras_n_out, cas_n_out, we_n_out} <= dc_ctrl_pkg::CMD_NOP;
            dc_done_out <= 1'b0;
            unique case (state_r)
                dc_ctrl_pkg::ST_IDLE: begin
                    if (take_host) begin
                        {ras_n_out, cas_n_out, we_n_out} <= enc_cmd;
                        local_mem_addr_out <= enc_addr;
                        state_r            <= dc_ctrl_pkg::ST_ISSUE;
                    end else if (take_refresh) begin
                        {ras_n_out, cas_n_out, we_n_out} <= dc_ctrl_pkg::CMD_CBR_REFRESH;
                        state_r <= dc_ctrl_pkg::ST_RECOVER;
                    end
                end
                dc_ctrl_pkg::ST_ISSUE: begin
                    dc_done_out <= 1'b1;
                    state_r     <= dc_ctrl_pkg::ST_RECOVER;
                end
                dc_ctrl_pkg::ST_RECOVER: begin
                    state_r <= dc_ctrl_pkg::ST_IDLE;
                end
                default: begin
                    state_r <= dc_ctrl_pkg::ST_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

//--- design/dc_ctrl_pkg.sv
// Package with register map, field layout, command codes and timing for the display cache controller.
`default_nettype none
package dc_ctrl_pkg;
    // Register addresses; all but DRAM_CTRL_HI_ADDR are shared by I/O space and memory space offsets.
    localparam logic [15:0] MISC_OUT_WR_ADDR   = 16'h03C2;
    localparam logic [15:0] MISC_OUT_RD_ADDR   = 16'h03CC;
    localparam logic [15:0] GFX_INDEX_ADDR     = 16'h03CE;
    localparam logic [15:0] GFX_DATA_ADDR      = 16'h03CF;
    localparam logic [15:0] DRAM_CTRL_HI_ADDR  = 16'h3002;
    // Reset values.
    localparam logic [7:0]  MISC_OUT_RESET     = 8'h00;
    localparam logic [7:0]  DRAM_CTRL_HI_RESET = 8'h08;
    localparam logic [7:0]  GFX_REG_RESET      = 8'h00;
    // Field positions.
    localparam int          REFRESH_LSB        = 3;
    localparam int          MODE_LSB           = 0;
    localparam int          LEGACY_EN_BIT      = 1;
    localparam int          GFX_REG_COUNT      = 9;
    localparam logic [7:0]  DRAM_CTRL_HI_MASK  = 8'h1F;
    localparam logic [7:0]  MISC_OUT_MASK      = 8'h02;
    localparam logic [7:0]  GFX_INDEX_MASK     = 8'h0F;
    // Refresh rate encodings.
    localparam logic [1:0]  REFRESH_OFF        = 2'b00;
    localparam logic [1:0]  REFRESH_NORMAL     = 2'b01;
    // Special mode encodings.
    localparam logic [2:0]  MODE_NORMAL        = 3'b000;
    localparam logic [2:0]  MODE_NOP           = 3'b001;
    localparam logic [2:0]  MODE_PRECHARGE_ALL = 3'b010;
    localparam logic [2:0]  MODE_MODE_REG_SET  = 3'b011;
    localparam logic [2:0]  MODE_CBR_REFRESH   = 3'b100;
    // SDRAM command encodings as {ras_n, cas_n, we_n}.
    localparam logic [2:0]  CMD_NOP            = 3'b111;
    localparam logic [2:0]  CMD_READ           = 3'b101;
    localparam logic [2:0]  CMD_WRITE          = 3'b100;
    localparam logic [2:0]  CMD_PRECHARGE      = 3'b010;
    localparam logic [2:0]  CMD_MODE_REG_SET   = 3'b000;
    localparam logic [2:0]  CMD_CBR_REFRESH    = 3'b001;
    localparam int          ALL_BANKS_BIT      = 10;
    // Legacy window bounds.
    localparam logic [31:0] LEGACY_LO          = 32'h000A_0000;
    localparam logic [31:0] LEGACY_HI          = 32'h000B_FFFF;
    // Refresh interval, in ns, and as clock cycles at 250 MHz.
    localparam int          CLK_PERIOD_PS      = 4000;
    localparam int          REFRESH_INT_NS     = 15600;
    localparam int          REFRESH_CYCLES     = (REFRESH_INT_NS * 1000) / CLK_PERIOD_PS;
    localparam logic [11:0] REFRESH_COUNT      = REFRESH_CYCLES[11:0];
    // Controller states, Gray coded along the issue path.
    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_ISSUE   = 2'b01,
        ST_RECOVER = 2'b11
    } ctrl_state_t;
endpackage
`default_nettype wire

//--- design/sdram_cmd_encoder.sv
// Encoder that turns one cache cycle and the special mode into an SDRAM command and address.
`default_nettype none
module sdram_cmd_encoder (
    // Cycle description.
    input  wire logic [2:0]  mode_in,
    input  wire logic        write_in,
    input  wire logic [11:0] addr_in,
    // Encoded command.
    output logic      [2:0]  cmd_out,
    output logic      [11:0] addr_out
);
    // Pick the command that replaces the cycle for the selected mode.
    always_comb begin
        cmd_out  = write_in ? dc_ctrl_pkg::CMD_WRITE : dc_ctrl_pkg::CMD_READ;
        addr_out = addr_in;
        unique case (mode_in)
            // RQ4 nop replaces cycle
            dc_ctrl_pkg::MODE_NOP: begin
                cmd_out = dc_ctrl_pkg::CMD_NOP;
            end
            // RQ5 all-bank precharge
            dc_ctrl_pkg::MODE_PRECHARGE_ALL: begin
                cmd_out                              = dc_ctrl_pkg::CMD_PRECHARGE;
                addr_out[dc_ctrl_pkg::ALL_BANKS_BIT] = 1'b1;
            end
            // RQ6 mode register set
            dc_ctrl_pkg::MODE_MODE_REG_SET: begin
                cmd_out  = dc_ctrl_pkg::CMD_MODE_REG_SET;
                // RQ7 RQ8 value on low bits, upper zeroed
                addr_out = {5'b0_0000, addr_in[6:0]};
            end
            // RQ9 cbr refresh instead
            dc_ctrl_pkg::MODE_CBR_REFRESH: begin
                cmd_out = dc_ctrl_pkg::CMD_CBR_REFRESH;
            end
            // Normal and reserved encodings pass the cycle through.
            default: begin
                cmd_out = write_in ? dc_ctrl_pkg::CMD_WRITE : dc_ctrl_pkg::CMD_READ;
            end
        endcase
    end
endmodule
`default_nettype wire

//--- tb/dc_ctrl_props.sv
// Checker with concurrent assertions on the display cache controller ports.
`default_nettype none
module dc_ctrl_props (
    // Clock, reset and register access.
    input wire logic        clk_in,
    input wire logic        reset_in,
    input wire logic        reg_req_in,
    input wire logic        reg_is_mem_in,
    input wire logic        reg_write_in,
    input wire logic [15:0] reg_addr_in,
    input wire logic [7:0]  reg_wdata_in,
    input wire logic        reg_ack_out,
    input wire logic        reg_hit_out,
    input wire logic [7:0]  reg_rdata_out,
    // Processor claim.
    input wire logic [31:0] cpu_addr_in,
    input wire logic        lfb_hit_in,
    input wire logic        cpu_claim_out,
    // Cache cycles and SDRAM pins.
    input wire logic        dc_req_in,
    input wire logic        dc_write_in,
    input wire logic [11:0] dc_addr_in,
    input wire logic        dc_ready_out,
    input wire logic        dc_done_out,
    input wire logic        ras_n_out,
    input wire logic        cas_n_out,
    input wire logic        we_n_out,
    input wire logic [11:0] local_mem_addr_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    logic [2:0]  mode_r;
    logic        legacy_r;
    logic [11:0] addr_d;
    logic        take;
    logic [2:0]  cmd;
    logic        in_win;
    assign take   = dc_req_in && dc_ready_out;
    assign cmd    = {ras_n_out, cas_n_out, we_n_out};
    assign in_win = cpu_addr_in >= dc_ctrl_pkg::LEGACY_LO && cpu_addr_in <= dc_ctrl_pkg::LEGACY_HI;
    // Shadows of the special mode and legacy enable, plus the last cache address.
    always_ff @(posedge clk_in) begin
        addr_d <= dc_addr_in;
        if (reset_in) begin
            mode_r   <= dc_ctrl_pkg::MODE_NORMAL;
            legacy_r <= 1'b0;
        end else if (reg_req_in && reg_write_in) begin
            if (reg_is_mem_in && reg_addr_in == dc_ctrl_pkg::DRAM_CTRL_HI_ADDR) mode_r <= reg_wdata_in[2:0];
            if (reg_addr_in == dc_ctrl_pkg::MISC_OUT_WR_ADDR) legacy_r <= reg_wdata_in[1];
        end
    end
    ack_tracks_req_a: assert property (reg_ack_out == $past(reg_req_in)) else $error("ack not one cycle after request");
    index_upper_zero_a: assert property (reg_req_in && !reg_write_in && reg_addr_in == dc_ctrl_pkg::GFX_INDEX_ADDR
        |=> reg_rdata_out[7:4] == 4'h0) else $error("index upper bits not zero");
    nop_cmd_a: assert property (take && mode_r == dc_ctrl_pkg::MODE_NOP |=> cmd == dc_ctrl_pkg::CMD_NOP) else $error("nop mode");
    precharge_cmd_a: assert property (take && mode_r == dc_ctrl_pkg::MODE_PRECHARGE_ALL
        |=> cmd == dc_ctrl_pkg::CMD_PRECHARGE && local_mem_addr_out[10]) else $error("precharge mode");
    mode_set_cmd_a: assert property (take && mode_r == dc_ctrl_pkg::MODE_MODE_REG_SET
        |=> cmd == dc_ctrl_pkg::CMD_MODE_REG_SET && local_mem_addr_out == {5'h00, addr_d[6:0]}) else $error("mode set");
    cbr_cmd_a: assert property (take && mode_r == dc_ctrl_pkg::MODE_CBR_REFRESH |=> cmd == dc_ctrl_pkg::CMD_CBR_REFRESH)
        else $error("refresh mode");
    cycle_done_a: assert property (take |=> !dc_ready_out ##1 (dc_done_out && cmd == dc_ctrl_pkg::CMD_NOP))
        else $error("cache cycle not completed once");
    window_claim_a: assert property (in_win |-> cpu_claim_out == legacy_r) else $error("window claim wrong");
    lfb_claim_a: assert property (!in_win |-> cpu_claim_out == lfb_hit_in) else $error("frame buffer claim wrong");
    cover property (take && mode_r == dc_ctrl_pkg::MODE_MODE_REG_SET);
    cover property (in_win && cpu_claim_out);
    cover property (reg_ack_out && !reg_hit_out);
endmodule
`default_nettype wire

//--- tb/sdram_model.sv
// Behavioural SDRAM model that counts refresh commands and keeps its mode register.
`default_nettype none
module sdram_model (
    // Command pins.
    input  wire logic        clk_in,
    input  wire logic        ras_n_in,
    input  wire logic        cas_n_in,
    input  wire logic        we_n_in,
    input  wire logic [11:0] addr_in,
    // Observed state.
    output logic      [15:0] cbr_count_out,
    output logic      [11:0] mode_value_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cbr_count_out  = 16'h0000;
        mode_value_out = 12'h000;
    end
    // Count refresh commands and latch the mode register value.
    always @(posedge clk_in) begin
        if ({ras_n_in, cas_n_in, we_n_in} == dc_ctrl_pkg::CMD_CBR_REFRESH) cbr_count_out <= cbr_count_out + 16'h0001;
        if ({ras_n_in, cas_n_in, we_n_in} == dc_ctrl_pkg::CMD_MODE_REG_SET) mode_value_out <= addr_in;
    end
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Self-checking testbench for the display cache controller.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0, reset_in = 1'b1, reg_req_in = 1'b0, reg_is_mem_in = 1'b0, reg_write_in = 1'b0;
    logic [15:0] reg_addr_in = 16'h0000;
    logic [7:0]  reg_wdata_in = 8'h00, reg_rdata_out;
    logic        reg_ack_out, reg_hit_out, cpu_claim_out, dc_ready_out, dc_done_out, ras_n_out, cas_n_out, we_n_out;
    logic [31:0] cpu_addr_in = 32'h0000_0000;
    logic        lfb_hit_in = 1'b0, dc_req_in = 1'b0, dc_write_in = 1'b0;
    logic [11:0] dc_addr_in = 12'h000, local_mem_addr_out, mode_value;
    logic [15:0] cbr_count;
    int          failures = 0, n_compared = 0, cycles = 0;
    display_cache_sdram_ctrl display_cache_sdram_ctrl_inst (.clk_in, .reset_in, .reg_req_in, .reg_is_mem_in,
        .reg_write_in, .reg_addr_in, .reg_wdata_in, .reg_ack_out, .reg_hit_out, .reg_rdata_out, .cpu_addr_in,
        .lfb_hit_in, .cpu_claim_out, .dc_req_in, .dc_write_in, .dc_addr_in, .dc_ready_out, .dc_done_out,
        .ras_n_out, .cas_n_out, .we_n_out, .local_mem_addr_out);
    sdram_model sdram_model_inst (.clk_in, .ras_n_in(ras_n_out), .cas_n_in(cas_n_out), .we_n_in(we_n_out),
        .addr_in(local_mem_addr_out), .cbr_count_out(cbr_count), .mode_value_out(mode_value));
    // Clock and cycle ceiling.
    always #2 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One register access; ack, hit and read data are judged in the answer cycle.
    task automatic reg_chk(input logic mem, wr, input logic [15:0] addr, input logic [7:0] wd, input logic hit,
                           input logic [7:0] rd);
        @(negedge clk_in);
        {reg_req_in, reg_is_mem_in, reg_write_in, reg_addr_in, reg_wdata_in} = {1'b1, mem, wr, addr, wd};
        @(negedge clk_in);
        reg_req_in = 1'b0;
        chk({6'h00, reg_ack_out, reg_hit_out, reg_rdata_out}, {6'h00, 1'b1, hit, rd});
    endtask
    // One cache cycle; the command is judged one cycle after the take, done one cycle later.
    task automatic dc_cyc(input logic wr, input logic [11:0] addr, input logic [2:0] cmd, input logic [11:0] mask,
                          input logic [11:0] exp);
        int n;
        n = 0;
        @(negedge clk_in);
        while (dc_ready_out !== 1'b1 && n < 10) begin
            @(negedge clk_in);
            n++;
        end
        chk(16'(dc_ready_out), 16'h0001);
        {dc_req_in, dc_write_in, dc_addr_in} = {1'b1, wr, addr};
        @(negedge clk_in);
        dc_req_in = 1'b0;
        chk({1'b0, ras_n_out, cas_n_out, we_n_out, local_mem_addr_out & mask}, {1'b0, cmd, exp});
        @(negedge clk_in);
        chk(16'(dc_done_out), 16'h0001);
    endtask
    task automatic t_regs;
        reg_chk(1, 0, dc_ctrl_pkg::DRAM_CTRL_HI_ADDR, 8'h00, 1, 8'h08);
        reg_chk(0, 0, dc_ctrl_pkg::MISC_OUT_RD_ADDR, 8'h00, 1, 8'h00);
        reg_chk(0, 0, dc_ctrl_pkg::DRAM_CTRL_HI_ADDR, 8'h00, 0, 8'h00);
        reg_chk(0, 1, dc_ctrl_pkg::GFX_INDEX_ADDR, 8'hF8, 1, 8'h00);
        reg_chk(1, 1, dc_ctrl_pkg::GFX_DATA_ADDR, 8'h5A, 1, 8'h00);
        reg_chk(0, 1, dc_ctrl_pkg::GFX_INDEX_ADDR, 8'h03, 1, 8'h00);
        reg_chk(0, 1, dc_ctrl_pkg::GFX_DATA_ADDR, 8'h33, 1, 8'h00);
        reg_chk(1, 1, dc_ctrl_pkg::GFX_INDEX_ADDR, 8'hF8, 1, 8'h00);
        reg_chk(0, 0, dc_ctrl_pkg::GFX_DATA_ADDR, 8'h00, 1, 8'h5A);
        reg_chk(1, 0, dc_ctrl_pkg::GFX_INDEX_ADDR, 8'h00, 1, 8'h08);
        reg_chk(0, 0, dc_ctrl_pkg::MISC_OUT_WR_ADDR, 8'h00, 0, 8'h00);
        reg_chk(0, 0, 16'h0100, 8'h00, 0, 8'h00);
        $display("t_regs finished");
    endtask
    task automatic t_claim;
        logic [31:0] a [5] = '{32'h000A_0000, 32'h000B_FFFF, 32'h0009_FFFF, 32'h000C_0000, 32'hF000_0000};
        for (int en = 0; en < 2; en++) begin
            reg_chk(1, 1, dc_ctrl_pkg::MISC_OUT_WR_ADDR, {6'h3F, en[0], 1'b1}, 1, 8'h00);
            reg_chk(0, 0, dc_ctrl_pkg::MISC_OUT_RD_ADDR, 8'h00, 1, {6'h00, en[0], 1'b0});
            for (int i = 0; i < 10; i++) begin
                @(negedge clk_in);
                {cpu_addr_in, lfb_hit_in} = {a[i / 2], i[0]};
                #1;
                chk(16'(cpu_claim_out), 16'(i < 4 ? en[0] : i[0]));
            end
        end
        $display("t_claim finished");
    endtask
    task automatic t_modes;
        logic [2:0] md [6] = '{3'b001, 3'b010, 3'b011, 3'b100, 3'b101, 3'b000};
        logic [2:0] cm [6] = '{3'b111, 3'b010, 3'b000, 3'b001, 3'b101, 3'b101};
        logic [11:0] mk [6] = '{12'h000, 12'h400, 12'hFFF, 12'h000, 12'hFFF, 12'hFFF};
        logic [11:0] ex [6] = '{12'h000, 12'h400, 12'h035, 12'h000, 12'hBB5, 12'hBB5};
        dc_cyc(1, 12'h123, dc_ctrl_pkg::CMD_WRITE, 12'hFFF, 12'h123);
        for (int i = 0; i < 6; i++) begin
            reg_chk(1, 1, dc_ctrl_pkg::DRAM_CTRL_HI_ADDR, {5'h01, md[i]}, 1, 8'h00);
            dc_cyc(0, 12'hBB5, cm[i], mk[i], ex[i]);
        end
        chk(16'(mode_value), 16'h0035);
        $display("t_modes finished");
    endtask
    task automatic t_refresh;
        logic [15:0] c;
        c = cbr_count;
        repeat (4000) @(negedge clk_in);
        chk(16'(cbr_count > c), 16'h0001);
        reg_chk(1, 1, dc_ctrl_pkg::DRAM_CTRL_HI_ADDR, 8'h00, 1, 8'h00);
        repeat (10) @(negedge clk_in);
        c = cbr_count;
        repeat (4000) @(negedge clk_in);
        chk(cbr_count, c);
        // A reserved refresh encoding must not refresh either.
        reg_chk(1, 1, dc_ctrl_pkg::DRAM_CTRL_HI_ADDR, 8'h18, 1, 8'h00);
        c = cbr_count;
        repeat (4000) @(negedge clk_in);
        chk(cbr_count, c);
        reg_chk(1, 1, dc_ctrl_pkg::DRAM_CTRL_HI_ADDR, 8'h08, 1, 8'h00);
        $display("t_refresh finished");
    endtask
    // Reset in mid-run must bring the misc output back to its reset value; the DRAM control register, not yet written here, must read its reset value.
    task automatic t_reset;
        @(negedge clk_in);
        reset_in = 1'b1;
        repeat (2) @(negedge clk_in);
        reset_in = 1'b0;
        reg_chk(0, 0, dc_ctrl_pkg::MISC_OUT_RD_ADDR, 8'h00, 1, 8'h00);
        reg_chk(1, 0, dc_ctrl_pkg::DRAM_CTRL_HI_ADDR, 8'h00, 1, 8'h08);
        $display("t_reset finished");
    endtask
    task automatic report_and_stop;
        $display("Compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge clk_in);
        reset_in = 1'b0;
        t_regs();
        t_claim();
        t_reset();
        t_modes();
        t_refresh();
        report_and_stop();
    end
endmodule
bind display_cache_sdram_ctrl dc_ctrl_props dc_ctrl_props_inst (.clk_in, .reset_in, .reg_req_in, .reg_is_mem_in,
    .reg_write_in, .reg_addr_in, .reg_wdata_in, .reg_ack_out, .reg_hit_out, .reg_rdata_out, .cpu_addr_in,
    .lfb_hit_in, .cpu_claim_out, .dc_req_in, .dc_write_in, .dc_addr_in, .dc_ready_out, .dc_done_out,
    .ras_n_out, .cas_n_out, .we_n_out, .local_mem_addr_out);
`default_nettype wire
